// >>> rtl/esd_datapath.sv
// Purpose: Execute stage for sign-extend, float select and integer select-or-zero
// Assumes: Decode presents the instruction word and already-read operands with issue_valid
// Notes: Results are registered; writeback sees them one cycle after issue
`timescale 1ns/1ns
module esd_datapath #(
  parameter int XLEN     = 64,
  parameter int ARCH_REV = 6
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Issue from decode
  input  wire logic              issue_valid,
  input  wire logic [31:0]       instr,
  input  wire logic [XLEN-1:0]   first_source_val,
  input  wire logic [XLEN-1:0]   second_source_val,
  input  wire logic [63:0]       fp_source_val,
  input  wire logic [63:0]       fp_second_target_val,
  input  wire logic [63:0]       fp_dest_val,
  // Integer register writeback
  output logic                   int_wr_en,
  output logic [4:0]             int_wr_addr,
  output logic [XLEN-1:0]        int_wr_data,
  // Float register writeback
  output logic                   fp_wr_en,
  output logic [4:0]             fp_wr_addr,
  output logic [63:0]            fp_wr_data,
  output logic                   fp_wr_double,
  // Exceptions and status
  output logic                   reserved_instr,
  output logic                   fp_status_wr_en
);
  import esd_pkg::*;

  typedef struct packed {
    logic            int_we;
    logic [4:0]      int_addr;
    logic [XLEN-1:0] int_data;
    logic            fp_we;
    logic [4:0]      fp_addr;
    logic [63:0]     fp_data;
    logic            fp_dbl;
    logic            ri;
  } esd_state_type;

  esd_state_type st_q;
  esd_state_type st_d;

  logic [5:0] opc;
  logic [4:0] f_rs;
  logic [4:0] f_rt;
  logic [4:0] f_rd;
  logic [4:0] f_sa;
  logic [5:0] fn;
  logic       is_seb;
  logic       is_seh;
  logic       is_fsel;
  logic       fmt_ok;
  logic       is_select_if_zero_op;
  logic       is_select_if_nonzero_op;
  logic       cond_zero;
  logic       ext_ok;

  // Fixed R-type field slices of the issued word
  assign opc  = instr[31:ESD_OPC_POS];
  assign f_rs = instr[ESD_OPC_POS-1:ESD_RS_POS];
  assign f_rt = instr[ESD_RS_POS-1:ESD_RT_POS];
  assign f_rd = instr[ESD_RT_POS-1:ESD_RD_POS];
  assign f_sa = instr[ESD_RD_POS-1:ESD_SA_POS];
  assign fn   = instr[ESD_SA_POS-1:0];

  assign is_seb    = opc == ESD_OP_EXT3 && f_rs == 5'h00 && f_sa == ESD_SHAMT_SEB
                     && fn == ESD_FN_SHUFFLE;
  assign is_seh    = opc == ESD_OP_EXT3 && f_rs == 5'h00 && f_sa == ESD_SHAMT_SEH
                     && fn == ESD_FN_SHUFFLE;
  // Revision is fixed at build time, so the refusal costs no logic on later cores
  assign ext_ok    = ARCH_REV >= ESD_MIN_EXT_REV;
  assign is_fsel   = opc == ESD_OP_FPU && fn == ESD_FN_FSEL;
  assign fmt_ok    = f_rs == ESD_FMT_SINGLE || f_rs == ESD_FMT_DOUBLE;
  assign is_select_if_zero_op = opc == ESD_OP_SPECIAL && f_sa == 5'h00 && fn == ESD_FN_SELECT_IF_ZERO_OP;
  assign is_select_if_nonzero_op = opc == ESD_OP_SPECIAL && f_sa == 5'h00 && fn == ESD_FN_SELECT_IF_NONZERO_OP;
  // Whole-register test: a narrower compare would miss conditions in the upper half
  assign cond_zero = second_source_val == '0;

  // Decodes are mutually exclusive; the order only puts refusals ahead of writes
  always_comb begin
    st_d = '0;
    if (issue_valid) begin
      if ((is_seb || is_seh) && !ext_ok) begin
        st_d.ri = 1'b1;
      end else if (is_seb) begin
        st_d.int_we   = 1'b1;
        st_d.int_addr = f_rd;
        st_d.int_data = {{(XLEN-8){first_source_val[7]}}, first_source_val[7:0]};
      end else if (is_seh) begin
        st_d.int_we   = 1'b1;
        st_d.int_addr = f_rd;
        st_d.int_data = {{(XLEN-16){first_source_val[15]}}, first_source_val[15:0]};
      end else if (is_fsel && !fmt_ok) begin
        st_d.ri = 1'b1;
      end else if (is_fsel) begin
        st_d.fp_we   = 1'b1;
        st_d.fp_addr = f_sa;
        st_d.fp_dbl  = f_rs == ESD_FMT_DOUBLE;
        // Condition is the old destination value, bit 0 only
        st_d.fp_data = fp_dest_val[0] ? fp_second_target_val : fp_source_val;
        // Bits above single width are don't-care; zero keeps results repeatable
        if (!st_d.fp_dbl) begin
          st_d.fp_data[ESD_DOUBLE_W-1:ESD_SINGLE_W] = '0;
        end
      end else if (is_select_if_zero_op || is_select_if_nonzero_op) begin
        st_d.int_we   = 1'b1;
        st_d.int_addr = f_rd;
        if (is_select_if_zero_op ? cond_zero : !cond_zero) begin
          st_d.int_data = first_source_val;
        end else begin
          st_d.int_data = '0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign int_wr_en       = st_q.int_we;
  assign int_wr_addr     = st_q.int_addr;
  assign int_wr_data     = st_q.int_data;
  assign fp_wr_en        = st_q.fp_we;
  assign fp_wr_addr      = st_q.fp_addr;
  assign fp_wr_data      = st_q.fp_data;
  assign fp_wr_double    = st_q.fp_dbl;
  assign reserved_instr  = st_q.ri;
  // Status is never written: the select cannot trap, not even on NaN patterns
  assign fp_status_wr_en = 1'b0;

  // Sign-extend checks; an instance below revision 2 exercises the refusal path
  a_seb_result: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_seb && ext_ok |=> int_wr_en
    && int_wr_data == {{(XLEN-8){$past(first_source_val[7])}}, $past(first_source_val[7:0])})
    else $error("byte sign-extend result wrong");
  a_seh_result: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_seh && ext_ok |=> int_wr_en
    && int_wr_data[15:0] == $past(first_source_val[15:0])
    && int_wr_data[XLEN-1] == $past(first_source_val[15]))
    else $error("halfword sign-extend result wrong");
  a_seh_full: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_seh && ext_ok |=> int_wr_en
    && int_wr_data == {{(XLEN-16){$past(first_source_val[15])}}, $past(first_source_val[15:0])})
    else $error("halfword sign-extend upper bits wrong");
  a_ext_addr: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && (is_seb || is_seh) && ext_ok |=> int_wr_addr == $past(f_rd) && !fp_wr_en)
    else $error("sign-extend wrote wrong register");
  a_ext_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && (is_seb || is_seh) |=> reserved_instr == !ext_ok && int_wr_en == ext_ok)
    else $error("sign-extend revision gating wrong");

  // Float select checks
  a_fsel_pick: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_fsel && fmt_ok && f_rs == ESD_FMT_DOUBLE |=> fp_wr_en
    && fp_wr_data == ($past(fp_dest_val[0]) ? $past(fp_second_target_val)
                                            : $past(fp_source_val)))
    else $error("float select picked wrong operand");
  a_fsel_single: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_fsel && f_rs == ESD_FMT_SINGLE |=> fp_wr_en
    && fp_wr_data[31:0] == ($past(fp_dest_val[0]) ? $past(fp_second_target_val[31:0])
                                                  : $past(fp_source_val[31:0])))
    else $error("single float select picked wrong operand");
  a_fsel_dest: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_fsel && fmt_ok |=> fp_wr_addr == $past(f_sa))
    else $error("float select wrote wrong register");
  a_fsel_width: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_fsel && f_rs == ESD_FMT_SINGLE |=> !fp_wr_double
    && fp_wr_data[63:32] == 32'h0)
    else $error("single select width wrong");
  a_fsel_double: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_fsel && f_rs == ESD_FMT_DOUBLE |=> fp_wr_double)
    else $error("double select width flag missing");
  a_fmt_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_fsel && !fmt_ok |=> reserved_instr && !fp_wr_en)
    else $error("bad format not reserved");
  a_ri_no_write: assert property (@(posedge clk) disable iff (!rst_n)
    reserved_instr |-> !int_wr_en && !fp_wr_en)
    else $error("reserved word still wrote a register");
  a_no_status: assert property (@(posedge clk) disable iff (!rst_n)
    fp_wr_en |-> !fp_status_wr_en && !reserved_instr)
    else $error("float select touched status");
  a_fsel_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_fsel && fmt_ok |=> !reserved_instr && !int_wr_en)
    else $error("float select raised an exception");

  // Integer select checks
  a_selz_true: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_select_if_zero_op && cond_zero |=> int_wr_data == $past(first_source_val))
    else $error("select-if-zero true case wrong");
  a_selnz_true: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && is_select_if_nonzero_op && !cond_zero |=> int_wr_data == $past(first_source_val))
    else $error("select-if-nonzero true case wrong");
  a_sel_false: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && ((is_select_if_zero_op && !cond_zero) || (is_select_if_nonzero_op && cond_zero))
    |=> int_wr_en && int_wr_data == '0)
    else $error("integer select false case not zero");
  a_sel_addr: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && (is_select_if_zero_op || is_select_if_nonzero_op) |=> int_wr_en && int_wr_addr == $past(f_rd)
    && !fp_wr_en && !reserved_instr)
    else $error("integer select wrote wrong register");

  // Writeback timing checks
  a_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    !issue_valid |=> !int_wr_en && !fp_wr_en && !reserved_instr)
    else $error("writeback without issue");
  a_unknown_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    issue_valid && !(is_seb || is_seh || is_fsel || is_select_if_zero_op || is_select_if_nonzero_op)
    |=> !int_wr_en && !fp_wr_en && !reserved_instr)
    else $error("unknown word produced writeback");
  a_one_port: assert property (@(posedge clk) disable iff (!rst_n)
    !(int_wr_en && fp_wr_en))
    else $error("both register files written at once");
endmodule : esd_datapath

// >>> rtl/esd_pkg.sv
// Purpose: Constants for the extend-and-select execute datapath
// Assumes: Instruction word is 32 bits; fields follow the standard R-type layout
// Notes:
package esd_pkg;
  localparam logic [5:0] ESD_OP_SPECIAL   = 6'h00;
  localparam logic [5:0] ESD_OP_EXT3      = 6'h1F;
  localparam logic [5:0] ESD_OP_FPU       = 6'h11;
  localparam logic [4:0] ESD_SHAMT_SEB    = 5'h10;
  localparam logic [4:0] ESD_SHAMT_SEH    = 5'h18;
  localparam logic [5:0] ESD_FN_SHUFFLE   = 6'h20;
  localparam logic [5:0] ESD_FN_FSEL      = 6'h10;
  localparam logic [5:0] ESD_FN_SELECT_IF_ZERO_OP    = 6'h35;
  localparam logic [5:0] ESD_FN_SELECT_IF_NONZERO_OP    = 6'h37;
  localparam logic [4:0] ESD_FMT_SINGLE   = 5'h10;
  localparam logic [4:0] ESD_FMT_DOUBLE   = 5'h11;
  localparam int         ESD_MIN_EXT_REV  = 2;
  localparam int         ESD_OPC_POS      = 26;
  localparam int         ESD_RS_POS       = 21;
  localparam int         ESD_RT_POS       = 16;
  localparam int         ESD_RD_POS       = 11;
  localparam int         ESD_SA_POS       = 6;
  localparam int         ESD_SINGLE_W     = 32;
  localparam int         ESD_DOUBLE_W     = 64;
endpackage : esd_pkg

// >>> sim/esd_regfile_model.sv
// Purpose: Decode-side register file that presents operands for the issued word
// Assumes: Operands follow the instruction word without delay
// Notes: The bench loads contents through hierarchy before each issue
`timescale 1ns/1ns
module esd_regfile_model
  import esd_pkg::*;
(
  // Issued word
  input  wire logic [31:0] instr,
  // Operands
  output logic      [63:0] first_source_val,
  output logic      [63:0] second_source_val,
  output logic      [63:0] fp_source_val,
  output logic      [63:0] fp_second_target_val,
  output logic      [63:0] fp_dest_val
);
  logic [63:0] integer_register [32];
  logic [63:0] float_register [32];
  // Sign-extends take their operand from the second field, routed to the first port
  assign first_source_val     = (instr[31:26] == ESD_OP_EXT3) ? integer_register[instr[20:16]]
                                                              : integer_register[instr[25:21]];
  assign second_source_val    = integer_register[instr[20:16]];
  assign fp_source_val        = float_register[instr[15:11]];
  assign fp_second_target_val = float_register[instr[20:16]];
  assign fp_dest_val          = float_register[instr[10:6]];
endmodule : esd_regfile_model

// >>> sim/extend_and_select_datapath_tb.sv
// Purpose: Random mix of extend and select words checked against a reference model
// Assumes: One issue every other cycle, result one edge after issue
// Notes: A second instance at revision 1 must refuse sign-extends
`timescale 1ns/1ns
module extend_and_select_datapath_tb;
  import esd_pkg::*;
  logic        clk = 0, rst_n = 0, issue_valid = 0, int_wr_en, fp_wr_en, fp_wr_double;
  logic        reserved_instr, fp_status_wr_en, old_rsv;
  logic [31:0] instr = 32'h0;
  logic [4:0]  int_wr_addr, fp_wr_addr;
  logic [63:0] int_wr_data, fp_wr_data, first_source_val, second_source_val;
  logic [63:0] fp_source_val, fp_second_target_val, fp_dest_val;
  int          errors = 0, comparisons = 0, seed = 32'hbf2b922e;
  always #4 clk = ~clk;
  esd_regfile_model u_esd_regfile_model (.instr, .first_source_val, .second_source_val,
    .fp_source_val, .fp_second_target_val, .fp_dest_val);
  esd_datapath u_esd_datapath (.clk, .rst_n, .issue_valid, .instr, .first_source_val,
    .second_source_val, .fp_source_val, .fp_second_target_val, .fp_dest_val, .int_wr_en,
    .int_wr_addr, .int_wr_data, .fp_wr_en, .fp_wr_addr, .fp_wr_data, .fp_wr_double,
    .reserved_instr, .fp_status_wr_en);
  esd_datapath #(.ARCH_REV(1)) u_esd_datapath_rev1 (.clk, .rst_n, .issue_valid, .instr,
    .first_source_val, .second_source_val, .fp_source_val, .fp_second_target_val,
    .fp_dest_val, .int_wr_en(), .int_wr_addr(), .int_wr_data(), .fp_wr_en(), .fp_wr_addr(),
    .fp_wr_data(), .fp_wr_double(), .reserved_instr(old_rsv), .fp_status_wr_en());
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task automatic issue(logic [31:0] w);
    logic [63:0] a, t, ei, ef;
    logic        ewi, ewf, er, ext, edbl;
    for (int i = 0; i < 32; i++) begin
      u_esd_regfile_model.integer_register[i] = (i == 0) ? 64'h0 : {$random(seed), $random(seed)};
      u_esd_regfile_model.float_register[i] = {$random(seed), $random(seed)};
    end
    a = u_esd_regfile_model.integer_register[w[25:21]];
    t = u_esd_regfile_model.integer_register[w[20:16]];
    {ewi, ewf, er, ei, ef} = '0;
    edbl = w[25:21] == ESD_FMT_DOUBLE;
    ext = w[31:26] == ESD_OP_EXT3 && w[5:0] == ESD_FN_SHUFFLE && w[25:21] == 5'h00;
    if (ext && w[10:6] == ESD_SHAMT_SEB) {ewi, ei} = {1'b1, {56{t[7]}}, t[7:0]};
    if (ext && w[10:6] == ESD_SHAMT_SEH) {ewi, ei} = {1'b1, {48{t[15]}}, t[15:0]};
    if (w[31:26] == ESD_OP_FPU && w[5:0] == ESD_FN_FSEL) begin
      ewf = w[25:21] == ESD_FMT_SINGLE || w[25:21] == ESD_FMT_DOUBLE;
      er  = !ewf;
      ef  = u_esd_regfile_model.float_register[w[10:6]][0] ? u_esd_regfile_model.float_register[w[20:16]]
                                                : u_esd_regfile_model.float_register[w[15:11]];
      if (w[25:21] == ESD_FMT_SINGLE) ef[63:32] = 32'h0;
    end
    if (w[31:26] == ESD_OP_SPECIAL && w[10:6] == 5'h00) begin
      if (w[5:0] == ESD_FN_SELECT_IF_ZERO_OP) {ewi, ei} = {1'b1, (t == 64'h0) ? a : 64'h0};
      if (w[5:0] == ESD_FN_SELECT_IF_NONZERO_OP) {ewi, ei} = {1'b1, (t != 64'h0) ? a : 64'h0};
    end
    issue_valid <= 1'b1;
    instr       <= w;
    @(posedge clk);
    issue_valid <= 1'b0;
    // Results stand only in the cycle after the taking edge
    @(negedge clk);
    check("int_wr_en", int_wr_en, ewi);
    check("fp_wr_en", fp_wr_en, ewf);
    check("reserved_instr", reserved_instr, er);
    check("rev1 reserved_instr", old_rsv, er | (ext & ewi));
    check("fp_status_wr_en", fp_status_wr_en, 0);
    if (ewi) check("int_wr_data", int_wr_data, ei);
    if (ewi) check("int_wr_addr", int_wr_addr, w[15:11]);
    if (ewf) check("fp_wr_data", fp_wr_data, ef);
    if (ewf) check("fp_wr_addr", {fp_wr_double, fp_wr_addr}, {edbl, w[10:6]});
    @(posedge clk);
  endtask : issue
  initial begin
    logic [31:0] w;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int n = 0; n < 400; n++) begin
      w = $random(seed);
      case ($unsigned($random(seed)) % 5)
        0: w = {ESD_OP_EXT3, 5'h00, w[20:11], ESD_SHAMT_SEB, ESD_FN_SHUFFLE};
        1: w = {ESD_OP_EXT3, 5'h00, w[20:11], ESD_SHAMT_SEH, ESD_FN_SHUFFLE};
        2: w = {ESD_OP_FPU, w[31] ? {4'h8, w[30]} : w[25:21], w[20:6], ESD_FN_FSEL};
        3: w = {ESD_OP_SPECIAL, w[25:21], w[1] ? 5'h00 : w[20:16], w[15:11], 5'h00,
                w[0] ? ESD_FN_SELECT_IF_ZERO_OP : ESD_FN_SELECT_IF_NONZERO_OP};
        default: ;
      endcase
      issue(w);
    end
    $display("Test random mix done");
    // Reset mid-run with an issue pending: writeback must stay quiet
    rst_n       <= 1'b0;
    issue_valid <= 1'b1;
    instr       <= {ESD_OP_EXT3, 5'h00, 10'h3FF, ESD_SHAMT_SEB, ESD_FN_SHUFFLE};
    @(posedge clk);
    issue_valid <= 1'b0;
    @(negedge clk);
    check("int_wr_en in reset", int_wr_en, 64'h0);
    check("rev1 reserved_instr in reset", old_rsv, 64'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    issue({ESD_OP_EXT3, 5'h00, 10'h3FF, ESD_SHAMT_SEH, ESD_FN_SHUFFLE});
    $display("Test reset mid-run done");
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule : extend_and_select_datapath_tb
